// ---- rtl/adcci_regs.vh ----
/*
 * register map, field positions, reset values and timing counts of the
 * converter control block.
 * assumes: included by the design files by bare name; Verilog-2005.
 */
`ifndef ADCCI_REGS_VH
`define ADCCI_REGS_VH

// register offsets (data-space locations, kept as indices)
`define ADCCI_RESULT_IDX       8'hd0
`define ADCCI_CONTROL_IDX      8'hd1
// byte address on the bus is four times the index
`define ADCCI_RESULT_ADDR      10'h0340
`define ADCCI_CONTROL_ADDR     10'h0344
`define ADCCI_ADDR_W           10

// control register fields
`define ADCCI_IRQ_EN_BIT       7
`define ADCCI_DONE_BIT         6
`define ADCCI_START_BIT        5
`define ADCCI_PWR_BIT          4
`define ADCCI_OSC_OFF_BIT      2
`define ADCCI_CONTROL_RESET    8'h40
`define ADCCI_RESULT_RESET     8'h00

// conversion time: 70 us at the 10 MHz core clock
`define ADCCI_CONV_TIME_NS     70000
`define ADCCI_CLK_PERIOD_NS    100
`define ADCCI_CONV_CYCLES      (`ADCCI_CONV_TIME_NS / `ADCCI_CLK_PERIOD_NS)
// cycles spent on each of the eight result bits
`define ADCCI_BIT_CYCLES       (`ADCCI_CONV_CYCLES / 8)
`define ADCCI_CNT_W            7

// result extremes
`define ADCCI_FULL_SCALE       8'hff
`define ADCCI_ZERO_SCALE       8'h00

`endif

// ---- rtl/adcci_sar.v ----
/*
 * successive-approximation sequencer: eight bits, msb first.
 * assumes: comparator input is synchronous to clk_i and answers the trial
 * word on dac_o in the same cycle; one clock, synchronous reset.
 */
`timescale 1ns/10ps
`include "adcci_regs.vh"

module adcci_sar (
	// clock and reset
	input  wire       clk_i,
	input  wire       reset_i,
	// control
	input  wire       start_i,
	input  wire       abort_i,
	// comparator side
	input  wire       comp_high_i,
	output wire [7:0] dac_o,
	// result
	output reg        done_o,
	output reg  [7:0] result_o,
	output wire       busy_o
);

	reg [7:0]             trial;
	reg [7:0]             bit_mask;
	reg [`ADCCI_CNT_W-1:0] bit_cnt;
	reg                   running;

	assign dac_o  = trial | bit_mask;
	assign busy_o = running;

	// start restarts at once, even mid conversion (abandon old one)
	always @(posedge clk_i) begin
		done_o <= 1'b0;
		if (reset_i || abort_i) begin
			running  <= 1'b0;
			trial    <= 8'h00;
			bit_mask <= 8'h00;
			bit_cnt  <= {`ADCCI_CNT_W{1'b0}};
			if (reset_i) begin
				result_o <= `ADCCI_RESULT_RESET;
			end
		end else if (start_i) begin
			running  <= 1'b1;
			trial    <= 8'h00;
			bit_mask <= 8'h80;
			bit_cnt  <= {`ADCCI_CNT_W{1'b0}};
		end else if (running) begin
			if (bit_cnt == `ADCCI_BIT_CYCLES - 1) begin
				bit_cnt <= {`ADCCI_CNT_W{1'b0}};
				// keep the trial bit when the input is at or above it
				if (bit_mask == 8'h01) begin
					result_o <= comp_high_i ? (trial | bit_mask) : trial;
					done_o   <= 1'b1;
					running  <= 1'b0;
					bit_mask <= 8'h00;
				end else begin
					if (comp_high_i) begin
						trial <= trial | bit_mask;
					end
					bit_mask <= bit_mask >> 1;
				end
			end else begin
				bit_cnt <= bit_cnt + 1'b1;
			end
		end
	end

endmodule // adcci_sar

// ---- rtl/adcci_avalon.v ----
/*
 * Avalon-MM slave front end: decodes a byte address into one register
 * select and answers each access after one wait cycle.
 * assumes: master holds the request until waitrequest is low.
 */
`timescale 1ns/10ps
`include "adcci_regs.vh"

module adcci_avalon (
	// clock and reset
	input  wire                    clk_i,
	input  wire                    reset_i,
	// bus side
	input  wire [`ADCCI_ADDR_W-1:0] address_i,
	input  wire                    read_i,
	input  wire                    write_i,
	output wire                    waitrequest_o,
	// register side
	output wire                    wr_ctrl_o,
	output wire                    rd_sel_ctrl_o,
	output wire                    rd_sel_result_o,
	output wire                    accept_o
);

	reg ack;
	reg wait_q;

	// one wait cycle, then accept; avoids combinational paths bus to bus.
	// waitrequest has a flop of its own so the top drives it straight
	always @(posedge clk_i) begin
		if (reset_i) begin
			ack    <= 1'b0;
			wait_q <= 1'b1;
		end else begin
			ack    <= (read_i || write_i) && !ack;
			wait_q <= !((read_i || write_i) && !ack);
		end
	end

	assign accept_o        = ack && (read_i || write_i);
	assign waitrequest_o   = wait_q;
	assign rd_sel_ctrl_o   = (address_i == `ADCCI_CONTROL_ADDR);
	assign rd_sel_result_o = (address_i == `ADCCI_RESULT_ADDR);
	assign wr_ctrl_o       = accept_o && write_i && rd_sel_ctrl_o;

endmodule // adcci_avalon

// ---- rtl/adcci_top.v ----
/*
 * converter control interface: control and result registers, conversion
 * sequencing, interrupt request, wait wake-up and stop shutdown.
 * assumes: one 10 MHz clock, synchronous active-high reset, an external
 * comparator answering the trial word; Avalon-MM register access.
 */
// What this block does
// - converter keeps running in wait; pending done interrupt wakes from wait
// - power bit 4 turns the converter on at 1, off at 0
// - finished conversion sets done bit 6; interrupt if enabled; wait wake only
// - done flag cleared only by start; writing zero leaves it
// - interrupt enable bit 7 gates the done interrupt
// - writing 1 to start bit 5 begins a conversion; 0 does nothing
// - each start write clears done flag at once and the pending interrupt one cycle later
// - start during a conversion abandons it and begins afresh
// - start bit always reads zero
// - result valid only while done reads 1
// - control at 0D1h, resets to 40h; bit 6 read-only, bit 5 write-only
// - read-only result at 0D0h, msb at bit 7
// - bit 2 disables main oscillator at 1; no effect on converter
// - input at or above high reference gives FFh, at or below low gives 00h
// - conversion lasts about 70 us
`timescale 1ns/10ps
`include "adcci_regs.vh"

module adcci_top (
	// clock and reset
	input  wire                    clk_i,
	input  wire                    reset_i,
	// avalon-mm slave
	input  wire [`ADCCI_ADDR_W-1:0] address_i,
	input  wire                    read_i,
	input  wire                    write_i,
	input  wire [31:0]             writedata_i,
	output reg  [31:0]             readdata_o,
	output wire                    waitrequest_o,
	// low-power mode status from the core
	input  wire                    wait_mode_i,
	input  wire                    stop_mode_i,
	// analog front end
	input  wire                    comp_high_i,
	output reg  [7:0]              dac_o,
	output reg                     converter_on_o,
	// system outputs
	output reg                     conv_irq_o,
	output reg                     wake_from_wait_o,
	output reg                     main_osc_disable_o
);

	// control register state
	reg        conv_irq_enable;
	reg        conv_done;
	reg        converter_power_on;
	reg        main_osc_disable;
	reg  [7:0] conversion_result;

	// bus decode
	wire       wr_ctrl;
	wire       sel_ctrl;
	wire       sel_result;
	wire       accept;

	// sequencer
	wire       start_pulse;
	wire       abort;
	wire       sar_done;
	wire [7:0] sar_result;
	wire [7:0] sar_dac;
	wire       sar_busy;
	wire [7:0] ctrl_read;

	adcci_avalon u_bus (
		.clk_i           (clk_i),
		.reset_i         (reset_i),
		.address_i       (address_i),
		.read_i          (read_i),
		.write_i         (write_i),
		.waitrequest_o   (waitrequest_o),
		.wr_ctrl_o       (wr_ctrl),
		.rd_sel_ctrl_o   (sel_ctrl),
		.rd_sel_result_o (sel_result),
		.accept_o        (accept)
	);

	// start only from a write of 1; a write of 0 is ignored
	assign start_pulse = wr_ctrl && writedata_i[`ADCCI_START_BIT];
	// power off or stop kills the conversion in flight
	assign abort = stop_mode_i || !converter_power_on;

	adcci_sar u_sar (
		.clk_i       (clk_i),
		.reset_i     (reset_i),
		.start_i     (start_pulse && !abort),
		.abort_i     (abort),
		.comp_high_i (comp_high_i),
		.dac_o       (sar_dac),
		.done_o      (sar_done),
		.result_o    (sar_result),
		.busy_o      (sar_busy)
	);

	// control bits written by software; bits 3, 1, 0 are not stored
	always @(posedge clk_i) begin
		if (reset_i) begin
			conv_irq_enable    <= 1'b0;
			converter_power_on <= 1'b0;
			main_osc_disable   <= 1'b0;
		end else if (wr_ctrl) begin
			conv_irq_enable    <= writedata_i[`ADCCI_IRQ_EN_BIT];
			converter_power_on <= writedata_i[`ADCCI_PWR_BIT];
			main_osc_disable   <= writedata_i[`ADCCI_OSC_OFF_BIT];
		end
	end

	// result register and done flag load on the same edge. the finish echo
	// is one cycle old, so a start write in that cycle is the later event
	// and clears the flag; done never stands over a running conversion
	always @(posedge clk_i) begin
		if (reset_i) begin
			conv_done         <= 1'b1;
			conversion_result <= `ADCCI_RESULT_RESET;
		end else begin
			if (start_pulse) begin
				conv_done <= 1'b0;
			end else if (sar_done) begin
				conv_done <= 1'b1;
			end
			if (sar_done) begin
				conversion_result <= sar_result;
			end
		end
	end

	// read view: start bit always zero, reserved bits zero
	assign ctrl_read = {conv_irq_enable, conv_done, 1'b0, converter_power_on,
		1'b0, main_osc_disable, 2'b00};

	// read data registered on the wait cycle, stands at the accept edge
	always @(posedge clk_i) begin
		if (reset_i) begin
			readdata_o <= 32'h0000_0000;
		end else if (read_i && !accept) begin
			if (sel_ctrl) begin
				readdata_o <= {24'h00_0000, ctrl_read};
			end else if (sel_result) begin
				readdata_o <= {24'h00_0000, conversion_result};
			end else begin
				readdata_o <= 32'h0000_0000;
			end
		end
	end

	// registered outputs to the rest of the chip
	always @(posedge clk_i) begin
		if (reset_i) begin
			conv_irq_o         <= 1'b0;
			wake_from_wait_o   <= 1'b0;
			main_osc_disable_o <= 1'b0;
			converter_on_o     <= 1'b0;
			dac_o              <= 8'h00;
		end else begin
			// irq follows flag and enable; enable clear silences it
			conv_irq_o         <= conv_done && conv_irq_enable;
			// only wait mode is left by the interrupt, never stop
			wake_from_wait_o   <= conv_done && conv_irq_enable && wait_mode_i
				&& !stop_mode_i;
			main_osc_disable_o <= main_osc_disable;
			// wait mode leaves the converter alone; stop forces it off
			converter_on_o     <= converter_power_on && !stop_mode_i;
			dac_o              <= sar_busy ? sar_dac : 8'h00;
		end
	end

endmodule // adcci_top

// ---- testbench/adcci_checker.sv ----
/* checker: bus wait state, interrupt, wake, power and oscillator relations.
   assumes: bound to adcci_top; one clock, synchronous reset. */
`timescale 1ns/10ps
`include "adcci_regs.vh"
module adcci_checker (
	// clock and reset
	input logic        clk_i,
	input logic        reset_i,
	// bus
	input logic [9:0]  address_i,
	input logic        read_i,
	input logic        write_i,
	input logic [31:0] writedata_i,
	input logic [31:0] readdata_o,
	input logic        waitrequest_o,
	// modes and outputs
	input logic        wait_mode_i,
	input logic        stop_mode_i,
	input logic        converter_on_o,
	input logic        conv_irq_o,
	input logic        wake_from_wait_o,
	input logic        main_osc_disable_o
);
	logic wc;
	logic rc;
	logic ow;
	// accepted control accesses
	assign wc = write_i && !waitrequest_o && address_i == `ADCCI_CONTROL_ADDR;
	assign rc = read_i && !waitrequest_o && address_i == `ADCCI_CONTROL_ADDR;
	// last oscillator bit written, to compare the pin against
	always_ff @(posedge clk_i) begin
		if (reset_i) ow <= 1'b0;
		else if (wc) ow <= writedata_i[2];
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	a_one_wait: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
		else $error("no answer after one wait");
	a_idle_wait: assert property (!(read_i || write_i) |=> waitrequest_o)
		else $error("waitrequest low while idle");
	a_start_reads0: assert property (rc |-> readdata_o[5] == 1'b0)
		else $error("start bit read as one");
	a_resv_read0: assert property (rc |-> readdata_o[3] == 1'b0 && readdata_o[1:0] == 2'b00)
		else $error("reserved bits read as one");
	a_wake_gated: assert property (wake_from_wait_o |-> conv_irq_o && $past(wait_mode_i))
		else $error("wake without wait and irq");
	a_stop_off: assert property (stop_mode_i |=> !converter_on_o)
		else $error("converter on in stop");
	a_start_clr: assert property (wc && writedata_i[5] |-> ##2 !conv_irq_o)
		else $error("irq kept after start");
	a_irq_masked: assert property (wc && !writedata_i[7] |-> ##2 !conv_irq_o)
		else $error("irq while disabled");
	a_pwr_off: assert property (wc && !writedata_i[4] |-> ##2 !converter_on_o)
		else $error("converter on after power off");
	a_osc_copy: assert property (wc ##2 1'b1 |-> main_osc_disable_o == ow)
		else $error("oscillator pin wrong");
endmodule // adcci_checker
bind adcci_top adcci_checker u_chk (.*);

// ---- testbench/adcci_analog_model.sv ----
/* analog input model: ideal comparator against the trial word.
   assumes: level_i held steady through a conversion. */
`timescale 1ns/10ps
module adcci_analog_model (
	input  logic [7:0] dac_i,
	input  logic [7:0] level_i,
	output logic       comp_high_o
);
	// ideal compare; full and zero scale fall out of it
	assign comp_high_o = level_i >= dac_i;
endmodule // adcci_analog_model

// ---- testbench/testbench.sv ----
/* bench: register accesses over avalon-mm, conversions, wait and stop.
   assumes: adcci_top with ideal comparator model; 10 MHz clock. */
`timescale 1ns/10ps
`include "adcci_regs.vh"
module testbench;
	localparam logic [9:0] C = `ADCCI_CONTROL_ADDR;
	localparam logic [9:0] R = `ADCCI_RESULT_ADDR;
	localparam int T = `ADCCI_CONV_CYCLES;
	logic clk_i, reset_i, read_i, write_i, wait_mode_i, stop_mode_i, comp_high_i;
	logic converter_on_o, conv_irq_o, wake_from_wait_o, main_osc_disable_o;
	logic waitrequest_o;
	logic [9:0] address_i;
	logic [31:0] writedata_i, readdata_o, q;
	logic [7:0] dac_o, vin;
	logic [7:0] lv [4] = '{8'hff, 8'h00, 8'ha5, 8'h5a};
	int failures, n_tests, n;
	adcci_top DUT (.*);
	adcci_analog_model u_ana (.dac_i(dac_o), .level_i(vin), .comp_high_o(comp_high_i));
	// clock
	initial begin
		clk_i = 0;
		forever #50 clk_i = ~clk_i;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one bus access; held until waitrequest is sampled low at a rising edge,
	// read data taken at that edge, released just after it
	task automatic acc(input logic w, input logic [9:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		address_i <= a;
		writedata_i <= d;
		write_i <= w;
		read_i <= !w;
		do begin
			@(posedge clk_i);
			k++;
		end while (waitrequest_o !== 1'b0 && k < 50);
		if (k >= 50) failures++;
		q = readdata_o;
		write_i <= 0;
		read_i <= 0;
	endtask
	task automatic rdc(input logic [9:0] a, input logic [31:0] e, input string nm);
		acc(0, a, 0);
		chk(nm, e, q);
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge clk_i);
	endtask
	// bounded wait for the done interrupt
	task automatic wirq();
		n = 0;
		while (conv_irq_o !== 1'b1 && n < 1000) begin
			@(negedge clk_i);
			n++;
		end
		if (n >= 1000) failures++;
	endtask
	task automatic end_of_test();
		$display("failures %0d n_tests %0d", failures, n_tests);
		if (failures == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// watchdog, far beyond the few thousand cycles needed
	initial begin
		repeat (20000) @(posedge clk_i);
		failures++;
		end_of_test();
	end
	// main sequence
	initial begin
		{reset_i, read_i, write_i, wait_mode_i, stop_mode_i} = 5'b1_0000;
		address_i = 0;
		writedata_i = 0;
		vin = 0;
		failures = 0;
		n_tests = 0;
		repeat (10) @(posedge clk_i);
		reset_i <= 0;
		rdc(C, 32'h0000_0040, "ctrl reset");
		rdc(R, 32'h0000_0000, "result reset");
		acc(1, 10'h0348, 32'h0000_00ff);
		rdc(10'h0348, 32'h0000_0000, "unmapped");
		rdc(C, 32'h0000_0040, "ctrl kept");
		acc(1, C, 32'h0000_0010);
		acc(1, C, 32'h0000_0090);
		rdc(C, 32'h0000_00d0, "done kept");
		cyc(2);
		chk("irq on", 1, conv_irq_o);
		foreach (lv[i]) begin
			vin <= lv[i];
			acc(1, C, 32'h0000_00b0);
			cyc(2);
			chk("irq clear", 0, conv_irq_o);
			rdc(C, 32'h0000_0090, "started");
			@(posedge clk_i) wait_mode_i <= 1;
			wirq();
			chk("wake", 1, wake_from_wait_o);
			@(posedge clk_i) wait_mode_i <= 0;
			rdc(C, 32'h0000_00d0, "done set");
			rdc(R, {24'h0, lv[i]}, "result");
		end
		// restart mid-run: a kept first run would finish too early
		vin <= 8'h33;
		acc(1, C, 32'h0000_00b0);
		cyc(30);
		chk("dac msb", 32'h0000_0080, dac_o);
		@(posedge clk_i) vin <= 8'hcc;
		acc(1, C, 32'h0000_00b0);
		wirq();
		chk("conv time", 1, n >= T - 8 && n <= T + 8);
		rdc(R, 32'h0000_00cc, "restart");
		chk("dac idle", 0, dac_o);
		acc(1, C, 32'h0000_0010);
		cyc(2);
		chk("irq off", 0, conv_irq_o);
		acc(1, C, 32'h0000_0014);
		cyc(2);
		chk("osc", 1, main_osc_disable_o);
		chk("conv on", 1, converter_on_o);
		rdc(C, 32'h0000_0054, "reserved");
		acc(1, C, 32'h0000_0030);
		cyc(10);
		@(posedge clk_i) stop_mode_i <= 1;
		cyc(2);
		chk("stop off", 0, converter_on_o);
		cyc(100);
		chk("stop dac", 0, dac_o);
		rdc(C, 32'h0000_0010, "aborted");
		@(posedge clk_i) stop_mode_i <= 0;
		// a conversion that survived stop would have finished by now
		cyc(T + 100);
		rdc(C, 32'h0000_0010, "stays aborted");
		acc(1, C, 32'h0000_0000);
		cyc(2);
		chk("power off", 0, converter_on_o);
		end_of_test();
	end
endmodule // testbench
